/* File: design/adc_seq_pkg.sv */
// Shared constants for the converter sequencer
package adc_seq_pkg;
   localparam int RESULT_BITS   = 12;
   localparam int SAMPLE_TADS   = 8;
   localparam int BIT_TADS      = 12;
   localparam int PIN_COUNT     = 16;
   localparam int CHAN_BITS     = 5;
   localparam logic [4:0] CHAN_HALF_VDD = 5'h1F;
   localparam logic [1:0] SHS_LONG      = 2'h2;
   localparam logic [2:0] CKR_DIV16     = 3'h0;
   localparam logic [2:0] CKR_DIV8      = 3'h1;
   localparam logic [2:0] CKR_DIV4      = 3'h2;
   localparam logic [2:0] CKR_DIV2      = 3'h3;
   localparam logic [2:0] CKR_DIV64     = 3'h4;
   localparam logic [2:0] CKR_DIV32     = 3'h5;
   localparam logic [2:0] CKR_DIV1      = 3'h6;
   localparam logic [5:0] DIV_MAX       = 6'h3F;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT
   } seq_state_t;
endpackage

/* File: design/tad_tick_gen.sv */
// Conversion clock tick generator: divided main clock or sub clock
`timescale 1ns/1ps
module tad_tick_gen (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       enable,
   input  wire logic [2:0] conv_clk_select,
   input  wire logic       green_mode,
   input  wire logic       sub_clock,
   output logic            tick
);
   logic [5:0] count;
   logic [5:0] limit;
   logic       sub_meta;
   logic       sub_sync;
   logic       sub_prev;
   logic       sub_rise;
   logic       use_sub;
   logic       div_hit;

   // Divider ratio minus one for each select code
   function automatic logic [5:0] ratio_limit(input logic [2:0] sel);
      unique case (sel)
         adc_seq_pkg::CKR_DIV16: ratio_limit = 6'h0F;
         adc_seq_pkg::CKR_DIV8:  ratio_limit = 6'h07;
         adc_seq_pkg::CKR_DIV4:  ratio_limit = 6'h03;
         adc_seq_pkg::CKR_DIV2:  ratio_limit = 6'h01;
         adc_seq_pkg::CKR_DIV64: ratio_limit = adc_seq_pkg::DIV_MAX;
         adc_seq_pkg::CKR_DIV32: ratio_limit = 6'h1F;
         adc_seq_pkg::CKR_DIV1:  ratio_limit = 6'h00;
         default:                ratio_limit = 6'h00;
      endcase
   endfunction

   // clock select
   // Green mode forces the sub clock regardless of select
   assign use_sub  = green_mode || (conv_clk_select == 3'h7);
   assign limit    = ratio_limit(conv_clk_select);
   assign div_hit  = (count >= limit);
   assign sub_rise = sub_sync && !sub_prev;
   assign tick     = enable && (use_sub ? sub_rise : div_hit);

   // Sub clock arrives from its own oscillator, so it is synchronised
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sub_meta <= 1'b0;
         sub_sync <= 1'b0;
         sub_prev <= 1'b0;
      end else begin
         sub_meta <= sub_clock;
         sub_sync <= sub_meta;
         sub_prev <= sub_sync;
      end
   end

   // Divider restarts whenever sequencing is idle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= 6'h00;
      end else if (!enable || div_hit || use_sub) begin
         count <= 6'h00;
      end else begin
         count <= count + 6'h01;
      end
   end
endmodule

/* File: design/sar_adc_sequencer.sv */
// Successive-approximation converter sequencer and result holding
`timescale 1ns/1ps
// Operation
// - Conversion lasts 8 sampling periods then 12 bit periods after start
// - Clock select picks main clock divider or sub clock; green forces sub
// - Conversion logic keeps running while the core sleeps
// - Run bit cleared by hardware at conversion end
// - Done flag set at conversion end
// - Completion wakes sleeping core when wake enable is set
// - Woken core vectors only with global interrupts on, else continues
// - Twelve-bit result written into low and high result registers
// - Sleep without wake enable shuts the conversion off
// - Channel change while reading results may clear both registers
// - Sixteen per-pin analog enable bits choose each pin's function
// - Five-bit channel select routes one input, incl. half supply
// - Half-supply channel enables divider; other channels disconnect it
module sar_adc_sequencer #(
   parameter int SAMPLE_TADS = adc_seq_pkg::SAMPLE_TADS,
   parameter int BIT_TADS    = adc_seq_pkg::BIT_TADS
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        run_set,
   input  wire logic        conv_power_on,
   input  wire logic [2:0]  conv_clk_select,
   input  wire logic [1:0]  sample_hold_select,
   input  wire logic        green_mode,
   input  wire logic        sub_clock,
   input  wire logic        sleep_active,
   input  wire logic        conv_wake_enable,
   input  wire logic        conv_irq_enable,
   input  wire logic        global_int_enable,
   input  wire logic        done_clear,
   input  wire logic        result_read,
   input  wire logic [4:0]  channel_select,
   input  wire logic [15:0] pin_analog_enable_in,
   input  wire logic        comparator,
   output logic             conv_run,
   output logic             conv_done_flag,
   output logic             wake_request,
   output logic             irq_vector_request,
   output logic [7:0]       result_low,
   output logic [7:0]       result_high,
   output logic             sample_enable,
   output logic [11:0]      dac_code,
   output logic [4:0]       mux_channel,
   output logic             divider_enable,
   output logic [15:0]      pin_analog_enable
);
   adc_seq_pkg::seq_state_t state;
   adc_seq_pkg::seq_state_t next_state;
   logic [4:0]  tad_count;
   logic [11:0] sar;
   logic [11:0] trial;
   logic [3:0]  bit_index;
   logic [3:0]  next_index;
   logic [11:0] next_sar;
   logic [11:0] next_trial;
   logic [11:0] keep_code;
   logic        conv_tick;
   logic        tick;
   logic        shut_off;
   logic        busy;
   logic        sample_last;
   logic        bit_last;
   logic        finish;
   logic        start;
   logic        chan_change;
   logic [4:0]  chan_prev;
   logic        next_done;

   ////////////////////////////////////////////////////////////////////
   // Conversion clock
   tad_tick_gen u_tick (
      .clk             (clk),
      .reset           (reset),
      .enable          (busy),
      .conv_clk_select (conv_clk_select),
      .green_mode      (green_mode),
      .sub_clock       (sub_clock),
      .tick            (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // Sequencing decode
   // sleep shut-off
   // Only sleep without wake enable, or loss of power, aborts
   assign shut_off    = (sleep_active && !conv_wake_enable) || !conv_power_on;
   assign busy        = (state != adc_seq_pkg::ST_IDLE);
   assign sample_last = (tad_count == 5'(SAMPLE_TADS - 1));
   assign bit_last    = (bit_index == 4'h0);
   assign finish      = (state == adc_seq_pkg::ST_CONVERT) && tick
                        && bit_last && !shut_off;
   assign start       = run_set && conv_power_on && !busy && !shut_off;
   assign trial       = sar | (12'h001 << bit_index);

   // bit decisions
   // Comparator answers the registered trial within one clock, so it is
   // read directly: a synchroniser would cost two clocks per bit and
   // could never keep up with the undivided conversion clock
   assign conv_tick  = tick && (state == adc_seq_pkg::ST_CONVERT);
   assign keep_code  = comparator ? trial : sar;
   assign next_sar   = start ? 12'h000 : (conv_tick ? keep_code : sar);
   assign next_index = start ? 4'(BIT_TADS - 1)
                       : (conv_tick && !bit_last) ? bit_index - 4'h1
                       : bit_index;
   assign next_trial = next_sar | (12'h001 << next_index);

   // State transitions; sleep stops the sequence only when wake enable is off
   always_comb begin
      next_state = state;
      unique case (state)
         adc_seq_pkg::ST_IDLE:
            if (start) begin
               next_state = adc_seq_pkg::ST_SAMPLE;
            end
         adc_seq_pkg::ST_SAMPLE:
            if (shut_off) begin
               next_state = adc_seq_pkg::ST_IDLE;
            end else if (tick && sample_last) begin
               next_state = adc_seq_pkg::ST_CONVERT;
            end
         adc_seq_pkg::ST_CONVERT:
            if (shut_off || finish) begin
               next_state = adc_seq_pkg::ST_IDLE;
            end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // runs in sleep
   // State register has no sleep term at all
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= adc_seq_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tad_count <= 5'h00;
         bit_index <= 4'h0;
         sar       <= 12'h000;
      end else begin
         sar       <= next_sar;
         bit_index <= next_index;
         if (start) begin
            tad_count <= 5'h00;
         end else if (tick && state == adc_seq_pkg::ST_SAMPLE) begin
            tad_count <= tad_count + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // done flag
   // Set wins over a same-cycle software clear
   assign next_done = finish ? 1'b1 : (done_clear ? 1'b0 : conv_done_flag);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         conv_run       <= 1'b0;
         conv_done_flag <= 1'b0;
      end else begin
         conv_run       <= (next_state != adc_seq_pkg::ST_IDLE);
         conv_done_flag <= next_done;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_request       <= 1'b0;
         irq_vector_request <= 1'b0;
      end else begin
         wake_request       <= finish && sleep_active && conv_wake_enable;
         irq_vector_request <= finish && conv_irq_enable && global_int_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // channel change during read
   assign chan_change = result_read && (channel_select != chan_prev);

   // result write
   // Completion takes priority over the clear on a clash
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         result_low  <= 8'h00;
         result_high <= 8'h00;
         chan_prev   <= 5'h00;
      end else begin
         chan_prev <= channel_select;
         if (finish) begin
            result_low  <= keep_code[7:0];
            result_high <= {4'h0, keep_code[11:8]};
         end else if (chan_change) begin
            result_low  <= 8'h00;
            result_high <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin function
   // divider gating
   // Divider follows the channel so it never draws idle current elsewhere
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_analog_enable <= 16'h0000;
         mux_channel       <= 5'h00;
         divider_enable    <= 1'b0;
         sample_enable     <= 1'b0;
         dac_code          <= 12'h000;
      end else begin
         pin_analog_enable <= pin_analog_enable_in;
         mux_channel       <= channel_select;
         divider_enable    <= (channel_select == adc_seq_pkg::CHAN_HALF_VDD);
         sample_enable     <= (next_state == adc_seq_pkg::ST_SAMPLE);
         dac_code          <= (next_state == adc_seq_pkg::ST_CONVERT)
                              ? next_trial : 12'h000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   // completion side effects
   chk_run_clears_done: assert property (
      @(posedge clk) disable iff (reset)
      finish |=> !conv_run && conv_done_flag)
      else $error("run not cleared or done not set at completion");
   chk_done_set_wins: assert property (
      @(posedge clk) disable iff (reset)
      (finish && done_clear) |=> conv_done_flag)
      else $error("done set lost to clear");
   chk_run_while_busy: assert property (
      @(posedge clk) disable iff (reset)
      conv_run == busy)
      else $error("run bit differs from conversion state");
   chk_wake_pulse: assert property (
      @(posedge clk) disable iff (reset)
      (finish && sleep_active && conv_wake_enable) |=> wake_request)
      else $error("no wake on completion");
   chk_vector_gate: assert property (
      @(posedge clk) disable iff (reset)
      irq_vector_request |-> $past(global_int_enable))
      else $error("vector request without global enable");
   chk_sleep_shutoff: assert property (
      @(posedge clk) disable iff (reset)
      (busy && sleep_active && !conv_wake_enable) |=> !busy)
      else $error("conversion not shut off in sleep");
   chk_divider_follow: assert property (
      @(posedge clk) disable iff (reset)
      ##1 divider_enable == ($past(channel_select) ==
      adc_seq_pkg::CHAN_HALF_VDD))
      else $error("divider does not follow channel");
   chk_sample_first: assert property (
      @(posedge clk) disable iff (reset)
      start |=> sample_enable)
      else $error("sampling did not follow start");
   chk_result_write: assert property (
      @(posedge clk) disable iff (reset)
      finish |=> {result_high, result_low} == {4'h0, $past(keep_code)})
      else $error("result registers do not hold the decided code");
   cov_complete: cover property (@(posedge clk) disable iff (reset) finish);
   cov_sleep_wake: cover property (@(posedge clk) disable iff (reset)
      wake_request);
   cov_abort: cover property (@(posedge clk) disable iff (reset)
      busy && shut_off);
   cov_clear: cover property (@(posedge clk) disable iff (reset)
      chan_change);
endmodule

/* File: tb/sar_core_model.sv */
// Analog core model: sample-hold and ideal comparator
`timescale 1ns/1ps
module sar_core_model (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        conv_active,
   input  wire logic        sample_enable,
   input  wire logic [11:0] dac_code,
   input  wire logic [11:0] level,
   output logic             comparator
);
   logic [11:0] held;
   logic        wobble;
   ////////////////////////////////////////
   // Hold follows the input while sampling; the wobble makes sure an
   // idle comparator is never read as a stable answer
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         held   <= 12'h000;
         wobble <= 1'b0;
      end else begin
         wobble <= ~wobble;
         if (sample_enable) begin
            held <= level;
         end
      end
   end
   // routed input compared
   // Trial bit is kept while the held level is at or above it
   assign comparator = conv_active ? (dac_code <= held) : wobble;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench;
   logic        clk, reset, run_set, conv_power_on, green_mode, sub_clock;
   logic        sleep_active, conv_wake_enable, conv_irq_enable;
   logic        global_int_enable, done_clear, result_read, comparator;
   logic        conv_run, conv_done_flag, wake_request, irq_vector_request;
   logic        sample_enable, divider_enable;
   logic [2:0]  conv_clk_select;
   logic [1:0]  sample_hold_select;
   logic [4:0]  channel_select, mux_channel;
   logic [15:0] pin_analog_enable_in, pin_analog_enable;
   logic [11:0] level, dac_code;
   logic [7:0]  result_low, result_high, exp_lo, exp_hi;
   int          error_cnt, num_checks, wake_cnt, irq_cnt, i, r;

   sar_adc_sequencer uut (.clk, .reset, .run_set, .conv_power_on,
      .conv_clk_select, .sample_hold_select, .green_mode, .sub_clock,
      .sleep_active, .conv_wake_enable, .conv_irq_enable,
      .global_int_enable, .done_clear, .result_read, .channel_select,
      .pin_analog_enable_in, .comparator, .conv_run, .conv_done_flag,
      .wake_request, .irq_vector_request, .result_low, .result_high,
      .sample_enable, .dac_code, .mux_channel, .divider_enable,
      .pin_analog_enable);

   sar_core_model core (.clk, .reset, .conv_active(conv_run),
      .sample_enable, .dac_code, .level, .comparator);
   ////////////////////////////////////////
   // Main clock, and a free sub clock of unrelated phase
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      sub_clock = 1'b0;
      #3;
      forever #36 sub_clock = ~sub_clock;
   end
   // Pulses last one cycle, so they are counted on every edge
   always @(posedge clk) begin
      if (wake_request === 1'b1) wake_cnt++;
      if (irq_vector_request === 1'b1) irq_cnt++;
   end
   ////////////////////////////////////////
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check_val(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_in(input string what, input int lo, input int hi,
                           input int got);
      num_checks++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic test_done;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Clocks per period; the sub clock is about seven clocks
   function automatic int div_of(input logic [2:0] sel);
      case (sel)
         adc_seq_pkg::CKR_DIV16: div_of = 16;
         adc_seq_pkg::CKR_DIV8:  div_of = 8;
         adc_seq_pkg::CKR_DIV4:  div_of = 4;
         adc_seq_pkg::CKR_DIV2:  div_of = 2;
         adc_seq_pkg::CKR_DIV64: div_of = 64;
         adc_seq_pkg::CKR_DIV32: div_of = 32;
         adc_seq_pkg::CKR_DIV1:  div_of = 1;
         default:                div_of = 7;
      endcase
   endfunction
   // One conversion; abort sleeps mid-run with wake enable off
   task automatic convert(input logic [2:0] sel, input logic [11:0] lvl,
                          input bit abort);
      int  n, d;
      bit  exp_w, exp_i;
      d = green_mode ? 7 : div_of(sel);
      exp_w = !abort && sleep_active && conv_wake_enable;
      exp_i = !abort && conv_irq_enable && global_int_enable;
      conv_clk_select = sel;
      level = lvl;
      done_clear = 1'b1;
      step;
      done_clear = 1'b0;
      check_val("done_clear", 16'h0000, {15'h0, conv_done_flag});
      step(2 * d + 4);
      wake_cnt = 0;
      irq_cnt = 0;
      run_set = 1'b1;
      step;
      for (n = 0; n < 3000 && conv_run === 1'b1; n++) begin
         run_set = (n == 5);
         // Clear held through runs on select code 6, green one included, so it meets the finish edge
         done_clear = !abort && (sel == 3'h6);
         if (abort && n == 10) begin
            sleep_active = 1'b1;
            conv_wake_enable = 1'b0;
         end
         step;
      end
      run_set = 1'b0;
      done_clear = 1'b0;
      if (n == 3000) begin
         error_cnt++;
         test_done;
      end
      if (abort) begin
         check_in("abort_cycles", 11, 13, n);
         check_val("abort_done", 16'h0000, {15'h0, conv_done_flag});
         sleep_active = 1'b0;
      end else begin
         check_in("conv_cycles", 19 * d, 21 * d + 4, n);
         check_val("done_flag", 16'h0001, {15'h0, conv_done_flag});
         exp_lo = lvl[7:0];
         exp_hi = {4'h0, lvl[11:8]};
      end
      check_val("result", {exp_hi, exp_lo}, {result_high, result_low});
      step;
      check_val("wake", {15'h0, exp_w}, 16'(wake_cnt));
      check_val("irq", {15'h0, exp_i}, 16'(irq_cnt));
   endtask
   ////////////////////////////////////////
   initial begin
      reset = 1'b1;
      {run_set, green_mode, sleep_active, conv_wake_enable} = 4'h0;
      {conv_irq_enable, global_int_enable, done_clear} = 3'h0;
      conv_power_on = 1'b1;
      result_read = 1'b0;
      conv_clk_select = 3'h0;
      sample_hold_select = adc_seq_pkg::SHS_LONG;
      {channel_select, pin_analog_enable_in, level} = 33'h0;
      {exp_lo, exp_hi} = 16'h0000;
      {error_cnt, num_checks, wake_cnt, irq_cnt} = 128'h0;
      repeat (10) @(posedge clk);
      #1;
      reset = 1'b0;
      r = $urandom(38);
      // Routing of channel, divider and pin enables
      for (i = 0; i < 24; i++) begin
         channel_select = i ? 5'($urandom) : adc_seq_pkg::CHAN_HALF_VDD;
         pin_analog_enable_in = 16'($urandom);
         step(2);
         check_val("mux", 16'(channel_select), 16'(mux_channel));
         check_val("divider", {15'h0, channel_select == 5'h1F},
                   {15'h0, divider_enable});
         check_val("pins", pin_analog_enable_in, pin_analog_enable);
      end
      // Every divider code, then full and empty scale on the fastest
      conv_irq_enable = 1'b1;
      for (i = 0; i < 9; i++) begin
         global_int_enable = i[0];
         convert((i > 6) ? 3'h6 : 3'(i),
                 (i == 7) ? 12'hFFF : (i == 8) ? 12'h000 : 12'($urandom),
                 1'b0);
      end
      // Sub clock by code, then forced by green mode
      convert(3'h7, 12'($urandom), 1'b0);
      green_mode = 1'b1;
      convert(3'h6, 12'($urandom), 1'b0);
      green_mode = 1'b0;
      // Completion while the core sleeps, then sleep without wake enable aborts a run
      sleep_active = 1'b1;
      conv_wake_enable = 1'b1;
      global_int_enable = 1'b0;
      convert(3'h3, 12'($urandom), 1'b0);
      global_int_enable = 1'b1;
      convert(3'h2, 12'($urandom), 1'b0);
      sleep_active = 1'b0;
      convert(3'h3, 12'($urandom), 1'b1);
      // Power dropped in mid-sample ends the run with no done flag
      step(8);
      run_set = 1'b1;
      step;
      run_set = 1'b0;
      check_val("power_run", 16'h0001, {15'h0, conv_run});
      conv_power_on = 1'b0;
      step;
      check_val("power_off", 16'h0000, {15'h0, conv_run});
      check_val("power_done", 16'h0000, {15'h0, conv_done_flag});
      conv_power_on = 1'b1;
      // Channel moves during a result read
      result_read = 1'b1;
      step;
      channel_select = channel_select + 5'h01;
      step(3);
      check_val("result_clear", 16'h0000, {result_high, result_low});
      result_read = 1'b0;
      test_done;
   end
endmodule
